// ---- design/uart_aux_pkg.sv ----
package uart_aux_pkg;

  // ****************************************
  // register offsets
  // ****************************************
  localparam logic [7:0] OFS_SOFT_RESET_CTL = 8'h88;
  localparam logic [7:0] OFS_RTS_MIRROR = 8'h8c;
  localparam logic [7:0] OFS_BREAK_MIRROR = 8'h90;
  localparam logic [7:0] OFS_DMA_MODE_MIRROR = 8'h94;
  localparam logic [7:0] OFS_FIFO_EN_MIRROR = 8'h98;
  localparam logic [7:0] OFS_RX_TRIG_MIRROR = 8'h9c;
  localparam logic [7:0] OFS_TX_EMPTY_TRIG_MIRROR = 8'ha0;
  localparam logic [7:0] OFS_TRANSMIT_HALT_CTL = 8'ha4;
  localparam logic [7:0] OFS_DMA_SOFT_ACK = 8'ha8;
  localparam logic [7:0] OFS_COMPONENT_VERSION = 8'hf8;
  localparam logic [7:0] OFS_COMPONENT_TYPE_ID = 8'hfc;
  localparam logic [7:0] OFS_FIFO_CONTROL_REG = 8'h08;
  localparam logic [7:0] OFS_LINE_CONTROL_REG = 8'h0c;
  localparam logic [7:0] OFS_MODEM_CONTROL_REG = 8'h10;

  // ****************************************
  // field positions
  // ****************************************
  localparam int BIT_SRST_UART = 0;
  localparam int BIT_SRST_RX_FIFO = 1;
  localparam int BIT_SRST_TX_FIFO = 2;
  localparam int BIT_FCR_FIFO_EN = 0;
  localparam int BIT_FCR_RX_RESET = 1;
  localparam int BIT_FCR_TX_RESET = 2;
  localparam int BIT_FCR_DMA_MODE = 3;
  localparam int LSB_FCR_TX_EMPTY_TRIG = 4;
  localparam int LSB_FCR_RX_TRIG = 6;
  localparam int BIT_LCR_BREAK = 6;
  localparam int BIT_MCR_RTS = 1;

  // ****************************************
  // reset values and identity
  // ****************************************
  localparam logic [1:0] RST_TRIG = 2'h0;
  localparam logic RST_BIT = 1'b0;
  localparam logic [6:0] RST_LCR_OTHER = 7'h00;
  localparam logic [3:0] RST_MCR_OTHER = 4'h0;
  // arbitrary neutral values
  localparam logic [31:0] DEF_VERSION = 32'h3030_3031;
  localparam logic [31:0] DEF_TYPE_ID = 32'h0000_0001;
  localparam int RESET_SYNC_STAGES = 2;

  // ****************************************
  // carriers
  // ****************************************
  typedef struct packed {
    logic [1:0] rx_trig;
    logic [1:0] tx_empty_trig;
    logic dma_mode;
    logic fifo_en;
  } fifo_ctl_t;

  typedef struct packed {
    logic tx_fifo_reset;
    logic rx_fifo_reset;
    logic dma_ack;
  } aux_pulse_t;

endpackage : uart_aux_pkg

// ---- design/uart_reset_sync.sv ----
`timescale 1ns/1ps
module uart_reset_sync #(
  parameter int STAGES = 2
) (
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic i_soft_rst,
  output logic o_rst_n
);
  // elaboration-time refusal: one stage would leave release metastable
  if (STAGES < 2) begin : g_stages_check
    $error("uart_reset_sync needs at least two stages");
  end

  logic [STAGES-1:0] sync_r;
  wire comb_rst_n = i_arst_n & ~i_soft_rst;

  // assert at once, release on the clock
  always_ff @(posedge i_clk or negedge comb_rst_n) begin
    if (!comb_rst_n) begin
      sync_r <= '0;
    end else begin
      sync_r <= {sync_r[STAGES-2:0], 1'b1};
    end
  end

  assign o_rst_n = sync_r[STAGES-1];
endmodule : uart_reset_sync

// ---- design/uart_shadow_aux_regs.sv ----
// Summary of operation
// - writing 1 to soft reset bit 0 resets uart at once, released on clock
// - software uart reset reaches both the bus and serial clock domains
// - soft reset bit 2 acts like the fifo control tx fifo reset bit
// - soft reset bit 1 acts like the fifo control rx fifo reset bit
// - rts mirror bit 0 reads and writes the modem control rts bit
// - break mirror bit 0 reads and writes line control break bit 6
// - dma mode mirror bit 0 reads and writes fifo control bit 3
// - fifo enable mirror bit 0 reads and writes fifo control bit 0
// - rx trigger mirror bits 1:0 track fifo control bits 7:6
// - tx empty trigger mirror bits 1:0 track fifo control bits 5:4
// - transmit halt bit stops the transmitter while set; resets to 0
// - halted tx with fifos on still accepts writes but never drains
// - writing 1 to dma ack bit 0 acknowledges the pending dma request
// - version register is a read-only 32-bit ascii version code
// - component type register is a read-only 32-bit ident code
`timescale 1ns/1ps
module uart_shadow_aux_regs
  import uart_aux_pkg::*;
#(
  parameter logic [31:0] VERSION_CODE = uart_aux_pkg::DEF_VERSION,
  parameter logic [31:0] COMPONENT_IDENT = uart_aux_pkg::DEF_TYPE_ID
) (
  input wire logic i_sys_clk,
  input wire logic i_reset_n,
  input wire logic i_clk_en,
  input wire logic i_serial_clk,
  // apb slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // engine side
  input wire logic i_tx_fifo_wr,
  output uart_aux_pkg::fifo_ctl_t o_fifo_ctl,
  output uart_aux_pkg::aux_pulse_t o_pulses,
  output logic o_break_ctl,
  output logic o_rts,
  output logic o_tx_halt,
  output logic o_tx_drain_en,
  output logic o_tx_fifo_accept,
  output logic o_pclk_rst_n,
  output logic o_sclk_rst_n
);

  // ****************************************
  // bus decode
  // ****************************************
  wire acc = i_psel & i_penable & i_clk_en;
  wire wr = acc & i_pwrite;
  wire hit_srst = (i_paddr == OFS_SOFT_RESET_CTL);
  wire hit_rts = (i_paddr == OFS_RTS_MIRROR);
  wire hit_brk = (i_paddr == OFS_BREAK_MIRROR);
  wire hit_dmam = (i_paddr == OFS_DMA_MODE_MIRROR);
  wire hit_fen = (i_paddr == OFS_FIFO_EN_MIRROR);
  wire hit_rxt = (i_paddr == OFS_RX_TRIG_MIRROR);
  wire hit_txt = (i_paddr == OFS_TX_EMPTY_TRIG_MIRROR);
  wire hit_halt = (i_paddr == OFS_TRANSMIT_HALT_CTL);
  wire hit_ack = (i_paddr == OFS_DMA_SOFT_ACK);
  wire hit_ver = (i_paddr == OFS_COMPONENT_VERSION);
  wire hit_ctr = (i_paddr == OFS_COMPONENT_TYPE_ID);
  wire hit_fcr = (i_paddr == OFS_FIFO_CONTROL_REG);
  wire hit_lcr = (i_paddr == OFS_LINE_CONTROL_REG);
  wire hit_mcr = (i_paddr == OFS_MODEM_CONTROL_REG);
  wire hit_any = hit_srst | hit_rts | hit_brk | hit_dmam | hit_fen | hit_rxt | hit_txt
               | hit_halt | hit_ack | hit_ver | hit_ctr | hit_fcr | hit_lcr | hit_mcr;

  // ****************************************
  // shared storage
  // ****************************************
  // one flop per bit: main and mirror addresses both land here
  fifo_ctl_t fctl_r;
  fifo_ctl_t fctl_nxt;
  logic brk_r;
  logic brk_nxt;
  logic [6:0] lcr_other_r;
  logic rts_r;
  logic rts_nxt;
  logic [3:0] mcr_other_r;
  logic halt_r;
  aux_pulse_t pulse_r;
  logic uart_srst_r;
  logic rst_n;

  wire wr_fcr = wr & hit_fcr;
  assign fctl_nxt.fifo_en = wr_fcr ? i_pwdata[BIT_FCR_FIFO_EN]
                          : (wr & hit_fen) ? i_pwdata[0] : fctl_r.fifo_en;
  assign fctl_nxt.dma_mode = wr_fcr ? i_pwdata[BIT_FCR_DMA_MODE]
                           : (wr & hit_dmam) ? i_pwdata[0] : fctl_r.dma_mode;
  assign fctl_nxt.rx_trig = wr_fcr ? i_pwdata[LSB_FCR_RX_TRIG +: 2]
                          : (wr & hit_rxt) ? i_pwdata[1:0] : fctl_r.rx_trig;
  assign fctl_nxt.tx_empty_trig = wr_fcr ? i_pwdata[LSB_FCR_TX_EMPTY_TRIG +: 2]
                                : (wr & hit_txt) ? i_pwdata[1:0] : fctl_r.tx_empty_trig;
  assign brk_nxt = (wr & hit_lcr) ? i_pwdata[BIT_LCR_BREAK]
                 : (wr & hit_brk) ? i_pwdata[0] : brk_r;
  assign rts_nxt = (wr & hit_mcr) ? i_pwdata[BIT_MCR_RTS]
                 : (wr & hit_rts) ? i_pwdata[0] : rts_r;

  // ****************************************
  // write-only pulses
  // ****************************************
  wire tx_rst_req = (wr & hit_srst & i_pwdata[BIT_SRST_TX_FIFO])
                  | (wr_fcr & i_pwdata[BIT_FCR_TX_RESET]);
  wire rx_rst_req = (wr & hit_srst & i_pwdata[BIT_SRST_RX_FIFO])
                  | (wr_fcr & i_pwdata[BIT_FCR_RX_RESET]);
  wire ack_req = wr & hit_ack & i_pwdata[0];
  wire uart_rst_req = wr & hit_srst & i_pwdata[BIT_SRST_UART];

  // ****************************************
  // registers, domain reset
  // ****************************************
  always_ff @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      fctl_r <= '{rx_trig: RST_TRIG, tx_empty_trig: RST_TRIG, dma_mode: RST_BIT,
                  fifo_en: RST_BIT};
      brk_r <= RST_BIT;
      lcr_other_r <= RST_LCR_OTHER;
      rts_r <= RST_BIT;
      mcr_other_r <= RST_MCR_OTHER;
      halt_r <= RST_BIT;
      pulse_r <= '0;
    end else if (i_clk_en) begin
      fctl_r <= fctl_nxt;
      brk_r <= brk_nxt;
      rts_r <= rts_nxt;
      if (wr & hit_lcr) begin
        lcr_other_r <= {i_pwdata[7], i_pwdata[5:0]};
      end
      if (wr & hit_mcr) begin
        mcr_other_r <= i_pwdata[5:2];
      end
      if (wr & hit_halt) begin
        halt_r <= i_pwdata[0];
      end
      // self-clearing, no software clear needed
      pulse_r <= '{tx_fifo_reset: tx_rst_req, rx_fifo_reset: rx_rst_req,
                   dma_ack: ack_req};
    end
  end

  // ****************************************
  // software uart reset
  // ****************************************
  // kept off the domain reset so the request survives its own effect
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      uart_srst_r <= 1'b0;
    end else if (i_clk_en) begin
      uart_srst_r <= uart_rst_req;
    end
  end

  uart_reset_sync #(
    .STAGES(RESET_SYNC_STAGES)
  ) u_pclk_rst (
    .i_clk(i_sys_clk),
    .i_arst_n(i_reset_n),
    .i_soft_rst(uart_srst_r),
    .o_rst_n(rst_n)
  );

  // serial side gets the same async assert, its own clocked release
  uart_reset_sync #(
    .STAGES(RESET_SYNC_STAGES)
  ) u_sclk_rst (
    .i_clk(i_serial_clk),
    .i_arst_n(i_reset_n),
    .i_soft_rst(uart_srst_r),
    .o_rst_n(o_sclk_rst_n)
  );

  assign o_pclk_rst_n = rst_n;

  // ****************************************
  // read mux
  // ****************************************
  wire [7:0] fcr_rd = {fctl_r.rx_trig, fctl_r.tx_empty_trig, fctl_r.dma_mode, 2'b00,
                       fctl_r.fifo_en};
  wire [7:0] lcr_rd = {lcr_other_r[6], brk_r, lcr_other_r[5:0]};
  wire [7:0] mcr_rd = {2'b00, mcr_other_r[3:0], rts_r, 1'b0};
  wire [31:0] rd_val =
      hit_rts ? {31'h0000_0000, rts_r}
    : hit_brk ? {31'h0000_0000, brk_r}
    : hit_dmam ? {31'h0000_0000, fctl_r.dma_mode}
    : hit_fen ? {31'h0000_0000, fctl_r.fifo_en}
    : hit_rxt ? {30'h0000_0000, fctl_r.rx_trig}
    : hit_txt ? {30'h0000_0000, fctl_r.tx_empty_trig}
    : hit_halt ? {31'h0000_0000, halt_r}
    : hit_ver ? VERSION_CODE
    : hit_ctr ? COMPONENT_IDENT
    : hit_fcr ? {24'h0000_00, fcr_rd}
    : hit_lcr ? {24'h0000_00, lcr_rd}
    : hit_mcr ? {24'h0000_00, mcr_rd}
    : 32'h0000_0000;

  logic [31:0] prdata_r;
  always_ff @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata_r <= 32'h0000_0000;
    end else if (i_clk_en && i_psel && !i_penable && !i_pwrite) begin
      prdata_r <= rd_val;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign o_prdata = prdata_r;
  assign o_pready = 1'b1;
  assign o_pslverr = acc & ~hit_any;
  assign o_fifo_ctl = fctl_r;
  assign o_pulses = pulse_r;
  assign o_break_ctl = brk_r;
  assign o_rts = rts_r;
  assign o_tx_halt = halt_r;
  // halted: fifo still fills from the host only while fifo_en is set, nothing is popped
  assign o_tx_drain_en = ~halt_r;
  assign o_tx_fifo_accept = i_tx_fifo_wr & (fctl_r.fifo_en | ~halt_r);

endmodule : uart_shadow_aux_regs

// ---- sim/apb_host_model.sv ----
`timescale 1ns/1ps
module apb_host_model (
  input wire logic i_sys_clk,
  output logic o_psel,
  output logic o_penable,
  output logic o_pwrite,
  output logic [7:0] o_paddr,
  output logic [31:0] o_pwdata,
  input wire logic [31:0] i_prdata
);
  initial begin
    {o_psel, o_penable, o_pwrite, o_paddr, o_pwdata} = '0;
  end
  // zero-wait slave: access completes at the first access edge
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    @(posedge i_sys_clk);
    #2;
    o_psel = 1'b1;
    o_pwrite = w;
    o_paddr = a;
    o_pwdata = d;
    @(posedge i_sys_clk);
    #2;
    o_penable = 1'b1;
    @(posedge i_sys_clk);
    q = i_prdata;
    #2;
    o_psel = 1'b0;
    o_penable = 1'b0;
    // stale data is not left on the bus
    o_pwdata = ~d;
  endtask : xfer
endmodule : apb_host_model

// ---- sim/testbench.sv ----
`timescale 1ns/1ps
module testbench;
  import uart_aux_pkg::*;
  logic clk, sclk, rst_n, psel, pen, pwr, tx_wr, brk, rts, halt, drain, acc, prst_n, srst_n;
  logic cen, prdy, perr;
  int n_err = 0;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, q;
  fifo_ctl_t fctl;
  aux_pulse_t pul;
  int fail_count = 0, checked = 0, n_tx = 0, n_rx = 0, n_ack = 0;
  uart_shadow_aux_regs uart_shadow_aux_regs_inst (.i_sys_clk(clk), .i_reset_n(rst_n),
    .i_clk_en(cen), .i_serial_clk(sclk), .i_psel(psel), .i_penable(pen), .i_pwrite(pwr),
    .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(prdy), .o_pslverr(perr),
    .i_tx_fifo_wr(tx_wr), .o_fifo_ctl(fctl), .o_pulses(pul), .o_break_ctl(brk), .o_rts(rts),
    .o_tx_halt(halt), .o_tx_drain_en(drain), .o_tx_fifo_accept(acc), .o_pclk_rst_n(prst_n),
    .o_sclk_rst_n(srst_n));
  apb_host_model apb_host_model_inst (.i_sys_clk(clk), .o_psel(psel), .o_penable(pen),
    .o_pwrite(pwr), .o_paddr(paddr), .o_pwdata(pwdata), .i_prdata(prdata));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // serial clock unrelated to the bus clock
  initial begin
    sclk = 1'b0;
    #7;
    forever #18.5 sclk = ~sclk;
  end
  always @(posedge clk) begin
    if (pul.tx_fifo_reset === 1'b1) n_tx++;
    if (pul.rx_fifo_reset === 1'b1) n_rx++;
    if (pul.dma_ack === 1'b1) n_ack++;
    if (psel === 1'b1 && pen === 1'b1 && perr === 1'b1) n_err++;
  end
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb_host_model_inst.xfer(1'b1, a, d, q);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input string n);
    apb_host_model_inst.xfer(1'b0, a, 32'h0, q);
    chk(n, e, q);
  endtask : rd
  task automatic t_mirror;
    wr(OFS_RTS_MIRROR, 32'h1);
    chk("rts", 32'h1, {31'h0, rts});
    wr(OFS_MODEM_CONTROL_REG, 32'h0);
    rd(OFS_RTS_MIRROR, 32'h0, "rts mirror");
    wr(OFS_BREAK_MIRROR, 32'h1);
    chk("break", 32'h1, {31'h0, brk});
    rd(OFS_LINE_CONTROL_REG, 32'h0000_0040, "line ctl");
    wr(OFS_DMA_MODE_MIRROR, 32'h1);
    wr(OFS_FIFO_EN_MIRROR, 32'h1);
    wr(OFS_RX_TRIG_MIRROR, 32'h2);
    wr(OFS_TX_EMPTY_TRIG_MIRROR, 32'h3);
    chk("fifo ctl", 32'h0000_002f, {26'h0, fctl});
    rd(OFS_FIFO_CONTROL_REG, 32'h0000_00b9, "fifo ctl reg");
    wr(OFS_FIFO_CONTROL_REG, 32'h0000_0046);
    rd(OFS_RX_TRIG_MIRROR, 32'h1, "rx trig");
    rd(OFS_TX_EMPTY_TRIG_MIRROR, 32'h0, "tx trig");
    rd(OFS_DMA_MODE_MIRROR, 32'h0, "dma mode");
    rd(OFS_FIFO_EN_MIRROR, 32'h0, "fifo en");
    $display("test mirror done");
  endtask : t_mirror
  task automatic t_halt;
    rd(OFS_TRANSMIT_HALT_CTL, 32'h0, "halt reset");
    wr(OFS_TRANSMIT_HALT_CTL, 32'h1);
    tx_wr = 1'b1;
    #1;
    chk("drain", 32'h0, {31'h0, drain});
    chk("accept off", 32'h0, {31'h0, acc});
    wr(OFS_FIFO_EN_MIRROR, 32'h1);
    chk("accept on", 32'h1, {31'h0, acc});
    tx_wr = 1'b0;
    wr(OFS_TRANSMIT_HALT_CTL, 32'h0);
    chk("drain", 32'h1, {31'h0, drain});
    // clock enable low: the write must not land
    cen = 1'b0;
    wr(OFS_TRANSMIT_HALT_CTL, 32'h1);
    cen = 1'b1;
    rd(OFS_TRANSMIT_HALT_CTL, 32'h0, "halt frozen");
    $display("test halt done");
  endtask : t_halt
  task automatic t_pulse;
    wr(OFS_SOFT_RESET_CTL, 32'h6);
    wr(OFS_DMA_SOFT_ACK, 32'h1);
    rd(OFS_SOFT_RESET_CTL, 32'h0, "srst read");
    rd(OFS_DMA_SOFT_ACK, 32'h0, "ack read");
    chk("tx pulses", 32'h2, n_tx);
    chk("rx pulses", 32'h2, n_rx);
    chk("ack pulses", 32'h1, n_ack);
    wr(OFS_COMPONENT_VERSION, 32'h0);
    rd(OFS_COMPONENT_VERSION, DEF_VERSION, "version");
    rd(OFS_COMPONENT_TYPE_ID, DEF_TYPE_ID, "type id");
    chk("slave errors", 32'h0, n_err);
    rd(8'h40, 32'h0, "unmapped");
    chk("slave errors", 32'h1, n_err);
    chk("ready", 32'h1, {31'h0, prdy});
    $display("test pulse done");
  endtask : t_pulse
  task automatic t_srst;
    wr(OFS_TRANSMIT_HALT_CTL, 32'h1);
    wr(OFS_SOFT_RESET_CTL, 32'h1);
    @(posedge clk);
    #2;
    chk("resets low", 32'h0, {30'h0, prst_n, srst_n});
    repeat (8) @(posedge clk);
    chk("resets high", 32'h3, {30'h0, prst_n, srst_n});
    rd(OFS_TRANSMIT_HALT_CTL, 32'h0, "halt cleared");
    $display("test soft reset done");
  endtask : t_srst
  task automatic tally_and_finish;
    $display("checked %0d fail_count %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : tally_and_finish
  initial begin
    #100000;
    fail_count++;
    tally_and_finish;
  end
  initial begin
    rst_n = 1'b0;
    tx_wr = 1'b0;
    cen = 1'b1;
    repeat (5) @(posedge clk);
    #2;
    rst_n = 1'b1;
    repeat (3) @(posedge clk);
    t_mirror;
    t_halt;
    t_pulse;
    t_srst;
    tally_and_finish;
  end
endmodule : testbench
bind uart_shadow_aux_regs uart_aux_asserts #(.VERSION_CODE(VERSION_CODE),
  .COMPONENT_IDENT(COMPONENT_IDENT)) uart_aux_asserts_inst (.*);

// ---- sim/uart_aux_asserts.sv ----
`timescale 1ns/1ps
module uart_aux_asserts
  import uart_aux_pkg::*;
#(
  parameter logic [31:0] VERSION_CODE = DEF_VERSION,
  parameter logic [31:0] COMPONENT_IDENT = DEF_TYPE_ID
) (
  input wire logic i_sys_clk,
  input wire logic i_reset_n,
  input wire logic i_clk_en,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic i_tx_fifo_wr,
  input wire logic [31:0] o_prdata,
  input wire uart_aux_pkg::fifo_ctl_t o_fifo_ctl,
  input wire uart_aux_pkg::aux_pulse_t o_pulses,
  input wire logic o_break_ctl,
  input wire logic o_rts,
  input wire logic o_tx_halt,
  input wire logic o_tx_drain_en,
  input wire logic o_tx_fifo_accept,
  input wire logic o_pclk_rst_n,
  input wire logic o_sclk_rst_n
);
  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (!i_reset_n);
  logic wr;
  logic rd;
  assign wr = i_psel & i_penable & i_pwrite & i_clk_en;
  assign rd = i_psel & ~i_penable & ~i_pwrite;
  sequence pulse_s(s);
    s ##1 !s;
  endsequence
  // both domains held, bus side released within 1 to 6 cycles
  sequence srst_s;
    !o_pclk_rst_n && !o_sclk_rst_n ##[1:6] o_pclk_rst_n;
  endsequence
  uart_reset_a: assert property (
    wr && i_paddr == OFS_SOFT_RESET_CTL && i_pwdata[0] |=> srst_s) else $error("soft reset");
  tx_pulse_a: assert property (
    wr && i_paddr == OFS_SOFT_RESET_CTL && i_pwdata[2] |=> pulse_s(o_pulses.tx_fifo_reset))
    else $error("tx fifo reset pulse");
  dma_ack_a: assert property (
    wr && i_paddr == OFS_DMA_SOFT_ACK && i_pwdata[0] |=> pulse_s(o_pulses.dma_ack))
    else $error("dma ack pulse");
  rts_mirror_a: assert property (
    wr && i_paddr == OFS_RTS_MIRROR |=> o_rts == $past(i_pwdata[0])) else $error("rts");
  break_mirror_a: assert property (
    wr && i_paddr == OFS_BREAK_MIRROR |=> o_break_ctl == $past(i_pwdata[0])) else $error("brk");
  rx_trig_a: assert property (
    wr && i_paddr == OFS_RX_TRIG_MIRROR |=> o_fifo_ctl.rx_trig == $past(i_pwdata[1:0]))
    else $error("rx trigger");
  halt_ctl_a: assert property (
    wr && i_paddr == OFS_TRANSMIT_HALT_CTL |=> o_tx_halt == $past(i_pwdata[0])
    && o_tx_drain_en != o_tx_halt) else $error("halt");
  fill_accept_a: assert property (
    i_tx_fifo_wr && o_tx_halt && o_fifo_ctl.fifo_en |-> o_tx_fifo_accept) else $error("accept");
  version_read_a: assert property (
    rd && i_paddr == OFS_COMPONENT_VERSION |=> o_prdata == VERSION_CODE) else $error("version");
  type_read_a: assert property (
    rd && i_paddr == OFS_COMPONENT_TYPE_ID |=> o_prdata == COMPONENT_IDENT) else $error("type");
  wo_read_a: assert property (
    rd && (i_paddr == OFS_SOFT_RESET_CTL || i_paddr == OFS_DMA_SOFT_ACK) |=> o_prdata == '0)
    else $error("write-only read");
endmodule : uart_aux_asserts
